// ### verilog/mtc_cfg.svh
// Constants of the multichannel timer counter core.
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH

`define MTC_CNT_W        16
`define MTC_BYTE_W       8
`define MTC_PRESCALE_SELECT_W       3
`define MTC_DIV_W        7
`define MTC_NUM_CH       4
`define MTC_NUM_IN       5
`define MTC_TIN_IDX      4
`define MTC_MODE_W       2
`define MTC_MODE_MODULO  2'b00
`define MTC_MODE_UPDOWN  2'b10
`define MTC_SRC_W        2
`define MTC_SRC_SYSCLK   2'b00
`define MTC_SRC_GATED    2'b01
`define MTC_SRC_TIN      2'b10
`define MTC_CNT_RESET    16'h0000
`define MTC_CNT_ONE      16'h0001
`define MTC_PRESCALE_SELECT_RESET   3'h0
`define MTC_DIV_RESET    7'h00
`define MTC_DIV_ONE      7'h01
`define MTC_DIV_FULL     7'h7f
`define MTC_DIV_TOP      3'h7

`endif

// ### verilog/mtc_pkg.sv
// Types shared by the multichannel timer counter core.
package mtc_pkg;

  typedef logic [15:0] mtc_count_t;

  typedef enum logic
  {
    MTC_DIR_UP,
    MTC_DIR_DOWN
  } mtc_dir_t;

endpackage

// ### verilog/mtc_input_or.sv
// Merges pin and event sources of each timer input into one registered level.
`include "mtc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module mtc_input_or
  import mtc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  // Sources
  input  wire logic [`MTC_NUM_IN-1:0]  pin_i,
  input  wire logic [`MTC_NUM_IN-1:0]  event_i,
  // Merged inputs
  output logic      [`MTC_NUM_IN-1:0]  merged_o
);

  genvar g;

  generate
    for (g = 0; g < `MTC_NUM_IN; g = g + 1)
    begin : gen_in
      wire merged_d;
      // The idle source is held low outside, so the OR passes the live one.
      assign merged_d = pin_i[g] | event_i[g];
      always_ff @(posedge clock_i)
      begin
        if (!rst_n_i)
          merged_o[g] <= 1'b0;
        else
          merged_o[g] <= merged_d;
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### verilog/mtc_prescaler.sv
// Power-of-two prescaler of the system clock.
`include "mtc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module mtc_prescaler
  import mtc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  // Control
  input  wire logic                    clear_i,
  input  wire logic                    count_i,
  input  wire logic [`MTC_PRESCALE_SELECT_W-1:0]  select_i,
  // Tick
  output logic                         tick_o
);

  logic [`MTC_DIV_W-1:0] div_q;
  logic [`MTC_DIV_W-1:0] div_d;
  wire  [`MTC_DIV_W-1:0] mask;

  // Divide by 2^select: tick when all masked low bits are ones.
  assign mask   = `MTC_DIV_FULL >> (`MTC_DIV_TOP - select_i);
  assign tick_o = count_i & ((div_q & mask) == mask);

  always_comb
  begin
    div_d = div_q;
    if (clear_i)
      div_d = `MTC_DIV_RESET;
    else if (count_i)
      div_d = div_q + `MTC_DIV_ONE;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      div_q <= `MTC_DIV_RESET;
    else
      div_q <= div_d;
  end

endmodule

`default_nettype wire

// ### verilog/mtc_core.sv
// Counter core of the multichannel timer: clocking, prescale and count modes.
//
// Function
// - 16-bit counter steps on selected timer clock.
// - Software reads and writes count high, low bytes.
// - Each timer input ORs pin and event source.
// - Source select picks sysclk, gated, or input.
// - Prescale field divides sysclk by powers two.
// - New prescale takes effect at cycle end, or at once when disabled.
// - Direct input clock bypasses the prescaler.
// - Counts only when enabled and source active.
// - Zero reload halts counter at zero, stays enabled.
// - Nonzero reload after halt resumes counting.
// - Mode field: 00 modulo, 10 up/down.
// - Modulo counts zero to reload, then wraps.
// - Modulo raises cycle request at reload-to-zero.
// - Modulo above reload restarts from zero at once.
// - Up/down counts to reload, back to zero.
// - Up/down raises cycle request reaching zero downward.
// - Timer output drives pin and event together.
// - Cycle request issued only when enabled.
// - Disabled block freezes; registers stay accessible.
`include "mtc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module mtc_core
  import mtc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  // Timer control zero
  input  wire logic [`MTC_SRC_W-1:0]   clock_source_select_i,
  input  wire logic                    cycle_interrupt_enable_i,
  // Timer control one
  input  wire logic                    counter_run_enable_i,
  input  wire logic [`MTC_PRESCALE_SELECT_W-1:0]  prescale_select_i,
  input  wire logic [`MTC_MODE_W-1:0]  count_mode_select_i,
  // Reload value
  input  wire logic [`MTC_CNT_W-1:0]   reload_value_i,
  // Count byte writes
  input  wire logic                    counter_high_byte_wr_i,
  input  wire logic                    counter_low_byte_wr_i,
  input  wire logic [`MTC_BYTE_W-1:0]  write_data_i,
  // Timer inputs from pins and event system
  input  wire logic [`MTC_NUM_CH-1:0]  channel_input_pins_i,
  input  wire logic [`MTC_NUM_CH-1:0]  channel_input_events_i,
  input  wire logic                    timer_input_pin_i,
  input  wire logic                    timer_input_event_i,
  // Merged timer inputs toward the channels
  output logic      [`MTC_NUM_CH-1:0]  channel_input_o,
  output logic                         timer_clock_gate_input_o,
  // Count state
  output logic      [`MTC_CNT_W-1:0]   count_o,
  output logic      [`MTC_BYTE_W-1:0]  counter_high_byte_o,
  output logic      [`MTC_BYTE_W-1:0]  counter_low_byte_o,
  output logic                         count_down_o,
  output logic                         halted_o,
  output logic      [`MTC_PRESCALE_SELECT_W-1:0]  prescale_active_o,
  // Cycle events
  output logic                         end_of_cycle_o,
  output logic                         cycle_irq_o,
  output logic                         timer_out_gpio_o,
  output logic                         timer_out_event_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------

  wire  [`MTC_NUM_IN-1:0] in_pin;
  wire  [`MTC_NUM_IN-1:0] in_event;
  logic [`MTC_NUM_IN-1:0] in_merged;
  wire                    timer_clock_gate_input;

  logic                   tin_prev_q;
  wire                    tin_rise;

  logic [`MTC_PRESCALE_SELECT_W-1:0] prescale_select_act_q;
  logic [`MTC_PRESCALE_SELECT_W-1:0] prescale_select_act_d;
  logic                   prescale_select_tick;
  wire                    prescale_select_count;
  wire                    prescale_select_clear;

  wire                    src_sys;
  wire                    src_gated;
  wire                    src_tin;
  wire                    src_active;
  wire                    step;

  wire                    mode_modulo;
  wire                    mode_updown;
  wire                    at_zero;
  wire                    at_one;
  wire                    at_reload;
  wire                    above_reload;
  wire                    reload_zero;
  wire                    halt;
  wire                    any_wr;

  mtc_count_t             cnt_q;
  mtc_count_t             cnt_d;
  mtc_dir_t               dir_q;
  mtc_dir_t               dir_d;
  logic                   eoc_d;
  logic                   eoc_q;
  logic                   irq_q;
  logic                   halt_q;
  wire                    irq_d;
  wire                    halt_d;

  // ----------------------------------------------------------------------
  // Timer inputs
  // ----------------------------------------------------------------------

  assign in_pin   = {timer_input_pin_i, channel_input_pins_i};
  assign in_event = {timer_input_event_i, channel_input_events_i};

  mtc_input_or u_input_or
  (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .pin_i    (in_pin),
    .event_i  (in_event),
    .merged_o (in_merged)
  );

  assign timer_clock_gate_input = in_merged[`MTC_TIN_IDX];

  // The input is sampled on the system clock; a rate of at most a quarter
  // of it guarantees that every high and low phase is seen.
  assign tin_rise = timer_clock_gate_input & ~tin_prev_q;

  // ----------------------------------------------------------------------
  // Clock source and prescaler
  // ----------------------------------------------------------------------

  assign src_sys    = (clock_source_select_i == `MTC_SRC_SYSCLK);
  assign src_gated  = (clock_source_select_i == `MTC_SRC_GATED);
  assign src_tin    = (clock_source_select_i == `MTC_SRC_TIN);

  // Gated source runs the prescaler only while the timer input is high.
  assign src_active = src_sys | (src_gated & timer_clock_gate_input);
  assign prescale_select_count = counter_run_enable_i & src_active;
  // A stopped block restarts the prescaler from a clean phase.
  assign prescale_select_clear = ~counter_run_enable_i;

  mtc_prescaler u_prescaler
  (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .clear_i  (prescale_select_clear),
    .count_i  (prescale_select_count),
    .select_i (prescale_select_act_q),
    .tick_o   (prescale_select_tick)
  );

  // The direct input clock does not go through the prescaler.
  assign step = counter_run_enable_i & (src_tin ? tin_rise : prescale_select_tick);

  // ----------------------------------------------------------------------
  // Count decode
  // ----------------------------------------------------------------------

  assign mode_modulo  = (count_mode_select_i == `MTC_MODE_MODULO);
  assign mode_updown  = (count_mode_select_i == `MTC_MODE_UPDOWN);
  assign at_zero      = (cnt_q == `MTC_CNT_RESET);
  assign at_one       = (cnt_q == `MTC_CNT_ONE);
  assign at_reload    = (cnt_q == reload_value_i);
  assign above_reload = (cnt_q > reload_value_i);
  assign reload_zero  = (reload_value_i == `MTC_CNT_RESET);
  // Halt is a level, so any nonzero reload lifts it on the next step.
  assign halt         = reload_zero & at_zero;
  assign any_wr       = counter_high_byte_wr_i | counter_low_byte_wr_i;

  // ----------------------------------------------------------------------
  // Counter next state
  // ----------------------------------------------------------------------

  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    eoc_d = 1'b0;
    if (any_wr)
    begin
      // Byte writes land at the next edge and counting goes on from there.
      if (counter_high_byte_wr_i)
        cnt_d[15:8] = write_data_i;
      if (counter_low_byte_wr_i)
        cnt_d[7:0] = write_data_i;
    end
    else if (!counter_run_enable_i)
    begin
      cnt_d = cnt_q;
    end
    else if (mode_modulo)
    begin
      dir_d = MTC_DIR_UP;
      if (above_reload)
        cnt_d = `MTC_CNT_RESET;
      else if (step && !halt)
      begin
        if (at_reload)
        begin
          cnt_d = `MTC_CNT_RESET;
          eoc_d = 1'b1;
        end
        else
          cnt_d = cnt_q + `MTC_CNT_ONE;
      end
    end
    else if (mode_updown)
    begin
      if (step && !halt)
      begin
        case (dir_q)
          MTC_DIR_UP:
          begin
            if (at_reload || above_reload)
            begin
              dir_d = MTC_DIR_DOWN;
              cnt_d = cnt_q - `MTC_CNT_ONE;
              if (at_one)
              begin
                dir_d = MTC_DIR_UP;
                eoc_d = 1'b1;
              end
            end
            else
              cnt_d = cnt_q + `MTC_CNT_ONE;
          end
          MTC_DIR_DOWN:
          begin
            if (at_zero)
              dir_d = MTC_DIR_UP;
            else
            begin
              cnt_d = cnt_q - `MTC_CNT_ONE;
              if (at_one)
              begin
                dir_d = MTC_DIR_UP;
                eoc_d = 1'b1;
              end
            end
          end
          default:
          begin
            dir_d = MTC_DIR_UP;
          end
        endcase
      end
    end
    else
    begin
      // Reserved codes freeze the count rather than guess at a mode.
      cnt_d = cnt_q;
    end
  end

  // ----------------------------------------------------------------------
  // Prescale buffer
  // ----------------------------------------------------------------------

  // A disabled block has no cycle to finish, so it takes the value at once.
  always_comb
  begin
    prescale_select_act_d = prescale_select_act_q;
    if (eoc_d || !counter_run_enable_i)
      prescale_select_act_d = prescale_select_i;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  // The request shares its flop timing with the cycle end, so both stand together.
  assign irq_d  = eoc_d & cycle_interrupt_enable_i;
  assign halt_d = halt & counter_run_enable_i;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= `MTC_CNT_RESET;
      dir_q <= MTC_DIR_UP;
    end
    else
    begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      eoc_q  <= 1'b0;
      irq_q  <= 1'b0;
      halt_q <= 1'b0;
    end
    else
    begin
      eoc_q  <= eoc_d;
      irq_q  <= irq_d;
      halt_q <= halt_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      tin_prev_q <= 1'b0;
      prescale_select_act_q <= `MTC_PRESCALE_SELECT_RESET;
    end
    else
    begin
      tin_prev_q <= timer_clock_gate_input;
      prescale_select_act_q <= prescale_select_act_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  assign count_o                  = cnt_q;
  assign counter_high_byte_o      = cnt_q[15:8];
  assign counter_low_byte_o       = cnt_q[7:0];
  assign count_down_o             = (dir_q == MTC_DIR_DOWN);
  assign halted_o                 = halt_q;
  assign prescale_active_o        = prescale_select_act_q;
  assign end_of_cycle_o           = eoc_q;
  assign cycle_irq_o              = irq_q;
  // Both consumers see the same flop, so they may be used together.
  assign timer_out_gpio_o         = eoc_q;
  assign timer_out_event_o        = eoc_q;
  assign channel_input_o          = in_merged[`MTC_NUM_CH-1:0];
  assign timer_clock_gate_input_o = timer_clock_gate_input;

endmodule

`default_nettype wire

// ### dv/mtc_core_properties.sv
// Port-level checks of the timer counter core.
`timescale 1ns/100ps
`default_nettype none

module mtc_core_properties
(
  // Inputs
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        cycle_interrupt_enable_i,
  input wire logic        counter_run_enable_i,
  input wire logic [1:0]  count_mode_select_i,
  input wire logic [15:0] reload_value_i,
  input wire logic        counter_high_byte_wr_i,
  input wire logic        counter_low_byte_wr_i,
  input wire logic [7:0]  write_data_i,
  input wire logic [3:0]  channel_input_pins_i,
  input wire logic [3:0]  channel_input_events_i,
  input wire logic        timer_input_pin_i,
  input wire logic        timer_input_event_i,
  // Outputs
  input wire logic [15:0] count_o,
  input wire logic        count_down_o,
  input wire logic        end_of_cycle_o,
  input wire logic        cycle_irq_o,
  input wire logic        timer_out_gpio_o,
  input wire logic        timer_out_event_o,
  input wire logic [3:0]  channel_input_o,
  input wire logic        timer_clock_gate_input_o
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // A byte write wins over a step, so steps are judged only without one.
  wire no_wr   = !counter_high_byte_wr_i && !counter_low_byte_wr_i;
  wire run_ok  = counter_run_enable_i && no_wr;
  wire mod_run = run_ok && count_mode_select_i == 2'b00;

  sequence s_at_reload;
    mod_run && count_o == reload_value_i && reload_value_i != 16'h0000;
  endsequence

  sequence s_moved;
    count_o != $past(count_o);
  endsequence

  a_wrap_to_zero: assert property (
    s_at_reload ##1 s_moved |-> count_o == 16'h0000 && end_of_cycle_o)
    else $error("wrap without cycle end");
  a_above_restart: assert property (
    mod_run && count_o > reload_value_i |=> count_o == 16'h0000 && !end_of_cycle_o)
    else $error("no restart above reload");
  a_updown_steps: assert property (
    run_ok && count_mode_select_i == 2'b10 && count_o <= reload_value_i |=>
      count_o == $past(count_o) || count_o == $past(count_o) + 16'h0001 ||
      count_o == $past(count_o) - 16'h0001)
    else $error("up down jump");
  a_updown_end: assert property (
    end_of_cycle_o && $past(count_mode_select_i) == 2'b10 |-> $past(count_o) == 16'h0001)
    else $error("up down end not from one");
  a_irq_gated: assert property (
    cycle_irq_o == (end_of_cycle_o && $past(cycle_interrupt_enable_i)))
    else $error("irq mismatch");
  a_outputs_pair: assert property (
    timer_out_gpio_o == end_of_cycle_o && timer_out_event_o == end_of_cycle_o)
    else $error("timer outputs differ");
  a_stop_freezes: assert property (
    !counter_run_enable_i && no_wr |=> $stable(count_o))
    else $error("count moved while stopped");
  a_reserved_holds: assert property (
    run_ok && count_mode_select_i[0] |=> $stable(count_o) && !end_of_cycle_o)
    else $error("reserved mode moved");
  a_high_byte_lands: assert property (
    counter_high_byte_wr_i |=> count_o[15:8] == $past(write_data_i))
    else $error("high byte lost");
  a_zero_reload_halts: assert property (
    mod_run && reload_value_i == 16'h0000 && count_o == 16'h0000 |=>
      count_o == 16'h0000 && !end_of_cycle_o)
    else $error("zero reload did not halt");
  a_direction_flag: assert property (
    $past(run_ok && count_mode_select_i == 2'b10) && count_o != $past(count_o) |->
      count_down_o == (count_o < $past(count_o) && count_o != 16'h0000))
    else $error("direction flag wrong");
  a_inputs_merged: assert property (
    channel_input_o == $past(channel_input_pins_i | channel_input_events_i) &&
      timer_clock_gate_input_o == $past(timer_input_pin_i | timer_input_event_i))
    else $error("timer inputs not merged");
endmodule

`default_nettype wire

// ### dv/mtc_input_source.sv
// Pin and event sources of the timer inputs.
`timescale 1ns/100ps
`default_nettype none

module mtc_input_source
(
  // Control
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic       use_event_i,
  input  wire logic [3:0] chan_i,
  // Sources
  output logic            timer_pin_o,
  output logic            timer_event_o,
  output logic      [3:0] chan_pin_o,
  output logic      [3:0] chan_event_o
);
  logic [1:0] phase_q;
  logic       level_q;

  // Toggling every fourth edge gives an eighth of the clock, safely under the quarter limit.
  always_ff @(posedge clock_i)
  begin
    phase_q <= (rst_n_i && run_i) ? phase_q + 2'h1 : 2'h0;
    level_q <= (rst_n_i && run_i) ? level_q ^ (phase_q == 2'h3) : 1'b0;
  end

  // Only the chosen path carries the level; the other is held low.
  assign timer_pin_o   = level_q & ~use_event_i;
  assign timer_event_o = level_q & use_event_i;
  assign chan_pin_o    = use_event_i ? 4'h0 : chan_i;
  assign chan_event_o  = use_event_i ? chan_i : 4'h0;
endmodule

`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench of the timer counter core.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [1:0]  src     = 2'b00;
  logic        irq_en  = 1'b0;
  logic        run_en  = 1'b0;
  logic [2:0]  prescale_select    = 3'h0;
  logic [1:0]  mode    = 2'b00;
  logic [15:0] reload  = 16'h0000;
  logic        hi_wr   = 1'b0;
  logic        lo_wr   = 1'b0;
  logic [7:0]  wdata   = 8'h00;
  logic [3:0]  chan    = 4'h0;
  logic        src_run = 1'b0;
  logic        use_ev  = 1'b0;
  logic        t_pin, t_ev, eoc, irq, halted;
  logic [3:0]  c_pin, c_ev, chan_in;
  logic [15:0] cnt;
  logic [7:0]  hi_b, lo_b;
  logic [2:0]  prescale_select_act;
  int          failures = 0;
  int          n_checks = 0;

  initial forever #10 clock_i = !clock_i;

  mtc_input_source i_src (.clock_i(clock_i), .rst_n_i(rst_n_i), .run_i(src_run),
    .use_event_i(use_ev), .chan_i(chan), .timer_pin_o(t_pin), .timer_event_o(t_ev),
    .chan_pin_o(c_pin), .chan_event_o(c_ev));

  mtc_core i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .clock_source_select_i(src), .cycle_interrupt_enable_i(irq_en),
    .counter_run_enable_i(run_en), .prescale_select_i(prescale_select),
    .count_mode_select_i(mode), .reload_value_i(reload),
    .counter_high_byte_wr_i(hi_wr), .counter_low_byte_wr_i(lo_wr),
    .write_data_i(wdata), .channel_input_pins_i(c_pin), .channel_input_events_i(c_ev),
    .timer_input_pin_i(t_pin), .timer_input_event_i(t_ev), .channel_input_o(chan_in),
    .timer_clock_gate_input_o(), .count_o(cnt), .counter_high_byte_o(hi_b),
    .counter_low_byte_o(lo_b), .count_down_o(), .halted_o(halted),
    .prescale_active_o(prescale_select_act), .end_of_cycle_o(eoc), .cycle_irq_o(irq),
    .timer_out_gpio_o(), .timer_out_event_o());

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr_byte(input logic hi, input logic [7:0] d);
    @(posedge clock_i);
    hi_wr <= hi;
    lo_wr <= !hi;
    wdata <= d;
    @(posedge clock_i);
    hi_wr <= 1'b0;
    lo_wr <= 1'b0;
  endtask

  task automatic sync_eoc;
    int k;
    k = 0;
    @(posedge clock_i);
    while (eoc !== 1'b1 && k < 1000)
    begin
      @(posedge clock_i);
      k++;
    end
    check("cycle end wait", {15'h0, eoc}, 16'h0001);
  endtask

  task automatic window(input int n, input int e, input int i);
    int ec;
    int ic;
    ec = 0;
    ic = 0;
    repeat (n)
    begin
      @(posedge clock_i);
      ec += (eoc === 1'b1);
      ic += (irq === 1'b1);
    end
    check("cycle ends", ec[15:0], e[15:0]);
    check("cycle irqs", ic[15:0], i[15:0]);
  endtask

  initial
  begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    check("count", cnt, 16'h0000);
    reload <= 16'h0002;
    irq_en <= 1'b1;
    run_en <= 1'b1;
    sync_eoc;
    window(30, 10, 10);
    irq_en <= 1'b0;
    prescale_select <= 3'h2;
    repeat (2) @(posedge clock_i);
    check("prescale", {13'h0, prescale_select_act}, 16'h0000);
    for (int p = 0; p < 8; p++)
    begin
      prescale_select <= p[2:0];
      sync_eoc;
      sync_eoc;
      window(6 << p, 2, 0);
    end
    prescale_select <= 3'h0;
    mode <= 2'b10;
    reload <= 16'h0003;
    sync_eoc;
    sync_eoc;
    window(60, 10, 0);
    run_en <= 1'b0;
    wr_byte(1'b1, 8'h01);
    wr_byte(1'b0, 8'h00);
    window(10, 0, 0);
    check("count", cnt, 16'h0100);
    check("high byte", {8'h0, hi_b}, 16'h0001);
    check("low byte", {8'h0, lo_b}, 16'h0000);
    for (int m = 1; m < 4; m += 2)
    begin
      mode <= m[1:0];
      run_en <= 1'b1;
      window(20, 0, 0);
      check("count", cnt, 16'h0100);
    end
    mode <= 2'b00;
    repeat (2) @(posedge clock_i);
    check("count", cnt, 16'h0000);
    reload <= 16'h0000;
    window(20, 0, 0);
    check("count", cnt, 16'h0000);
    check("halted", {15'h0, halted}, 16'h0001);
    reload <= 16'h0005;
    sync_eoc;
    check("halted", {15'h0, halted}, 16'h0000);
    window(60, 10, 0);
    src <= 2'b10;
    prescale_select <= 3'h7;
    reload <= 16'h0001;
    src_run <= 1'b1;
    sync_eoc;
    sync_eoc;
    window(160, 10, 0);
    use_ev <= 1'b1;
    prescale_select <= 3'h0;
    chan <= 4'ha;
    window(160, 10, 0);
    check("channel in", {12'h0, chan_in}, 16'h000a);
    src <= 2'b01;
    reload <= 16'h0003;
    chan <= 4'h5;
    use_ev <= 1'b0;
    sync_eoc;
    sync_eoc;
    window(80, 10, 0);
    check("channel in", {12'h0, chan_in}, 16'h0005);
    tally_and_finish;
  end

  // The run needs well under ten thousand cycles, so this limit only trips on a hang.
  initial
  begin
    repeat (20000) @(posedge clock_i);
    failures++;
    tally_and_finish;
  end
endmodule

bind mtc_core mtc_core_properties i_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .cycle_interrupt_enable_i(cycle_interrupt_enable_i),
  .counter_run_enable_i(counter_run_enable_i), .count_mode_select_i(count_mode_select_i),
  .reload_value_i(reload_value_i), .counter_high_byte_wr_i(counter_high_byte_wr_i),
  .counter_low_byte_wr_i(counter_low_byte_wr_i), .write_data_i(write_data_i),
  .channel_input_pins_i(channel_input_pins_i),
  .channel_input_events_i(channel_input_events_i),
  .timer_input_pin_i(timer_input_pin_i), .timer_input_event_i(timer_input_event_i),
  .count_o(count_o), .count_down_o(count_down_o), .end_of_cycle_o(end_of_cycle_o),
  .cycle_irq_o(cycle_irq_o), .timer_out_gpio_o(timer_out_gpio_o),
  .timer_out_event_o(timer_out_event_o), .channel_input_o(channel_input_o),
  .timer_clock_gate_input_o(timer_clock_gate_input_o));

`default_nettype wire
